// ---- verilog/wrp_pkg.sv ----
package wrp_pkg;
// Behaviour
// - Rectifier stays passive at start-up; synchronous mode only after lockout releases.
// - Lockout releases above 2.9 V rail and re-engages 200 mV lower.
// - Rail voltage and output current are sampled periodically for the control logic.
// - Rail below target asks lower frequency; rail above target asks higher frequency.
// - Rail target drops as regulator load current rises.
// - Rail above 13.5 V disables regulator, sends error packets, drives clamp drain.
// - Clamp stays active until rail falls below threshold minus hysteresis.
// - Select pin above 1.5 V picks 12 V; 0.7 V to 1.2 V picks 9 V.
// - Fallback enabled drops output to 5 V on a 5 W transmitter; else high impedance.
// - Quality factor 103, 80, 60, 40 or 20 follows the select pin level.
// - Over-limit current sets the current limit flag instead of cutting the output.
// - Current limit pin picks 1.6 A, 1 A, 0.8 A or 0.5 A.
// - Fault alert pulls low on shutdown, die over 140 C, thermistor, overload, overvoltage.
// - The triggering condition is recorded in a readable interrupt status register.
// - Shutdown request pin high disables the device; low activates it.
// - Die temperature above 140 C shuts the device down.
// - Die above 130 C sets the overheat flag and sends a power stop packet.
// - Thermistor input between 0.1 V and 0.6 V triggers over-temperature shutdown.
// - Thermistor input below 0.1 V ends charge with a power stop packet.

  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned SAMPLE_RATE_HZ = 67_500;
  localparam int unsigned SAMPLE_CYC     = CLK_HZ / SAMPLE_RATE_HZ;

  localparam logic [15:0] UNDERVOLTAGE_LOCKOUT_RISE_MV   = 16'h0b54;
  localparam logic [15:0] UNDERVOLTAGE_LOCKOUT_HYS_MV    = 16'h00c8;
  localparam logic [15:0] OV_RISE_MV     = 16'h34bc;
  localparam logic [15:0] OV_HYS_MV      = 16'h03e8;
  localparam logic [15:0] RAIL_BASE_12_MV = 16'h300c;
  localparam logic [15:0] RAIL_BASE_9_MV  = 16'h2454;
  localparam logic [15:0] RAIL_DROOP_MAX = 16'h0bb8;
  localparam logic [15:0] RAIL_BAND_MV   = 16'h0064;

  localparam logic [7:0]  DIE_SHUT_C     = 8'h8c;
  localparam logic [7:0]  DIE_COOL_C     = 8'h78;
  localparam logic [7:0]  DIE_WARN_C     = 8'h82;

  localparam logic [11:0] VSEL_12_CODE   = 12'hb6d;
  localparam logic [11:0] VSEL_9_HI_CODE = 12'h924;
  localparam logic [11:0] VSEL_9_LO_CODE = 12'h555;
  localparam logic [11:0] VSEL_12_STEP   = 12'h0ea;
  localparam logic [11:0] VSEL_9_STEP    = 12'h0c3;

  localparam logic [11:0] CURRENT_LIMIT_PIN_PULL_CODE = 12'h924;
  localparam logic [11:0] CURRENT_LIMIT_PIN_1A_CODE   = 12'h400;
  localparam logic [11:0] CURRENT_LIMIT_PIN_08_CODE   = 12'h2aa;
  localparam logic [15:0] CURRENT_LIMIT_PIN_16_MA     = 16'h0640;
  localparam logic [15:0] CURRENT_LIMIT_PIN_10_MA     = 16'h03e8;
  localparam logic [15:0] CURRENT_LIMIT_PIN_08_MA     = 16'h0320;
  localparam logic [15:0] CURRENT_LIMIT_PIN_05_MA     = 16'h01f4;

  localparam logic [11:0] THERM_HI_CODE  = 12'h492;
  localparam logic [11:0] THERM_LO_CODE  = 12'h0c3;

  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_MASK       = 8'h04;
  localparam logic [7:0]  REG_STATUS     = 8'h08;
  localparam logic [7:0]  REG_MEAS       = 8'h0c;
  localparam logic [7:0]  REG_STATE      = 8'h10;
  localparam logic [1:0]  CTRL_RESET     = 2'h1;
  localparam logic [6:0]  MASK_RESET     = 7'h7f;

  localparam int unsigned ST_SHUT_PIN = 0;
  localparam int unsigned ST_DIE_HOT  = 1;
  localparam int unsigned ST_THERM    = 2;
  localparam int unsigned ST_OC       = 3;
  localparam int unsigned ST_OV       = 4;
  localparam int unsigned ST_DIE_WARN = 5;
  localparam int unsigned ST_EOC      = 6;

  typedef enum logic [1:0] {
    WRP_PASSIVE  = 2'b00,
    WRP_ACTIVE   = 2'b01,
    WRP_SHUTDOWN = 2'b10
  } wrp_state_t;

  typedef enum logic [1:0] {
    WRP_OUT_12V = 2'b00,
    WRP_OUT_9V  = 2'b01,
    WRP_OUT_5V  = 2'b10
  } wrp_vout_t;

endpackage : wrp_pkg

// ---- verilog/wrp_hyst.sv ----
`timescale 1ns/10ps
`default_nettype none
module wrp_hyst #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] val,
  input  wire logic [W-1:0] on_th,
  input  wire logic [W-1:0] off_th,
  output var  logic         hit_q
);
  logic hit_d;

  always_comb begin
    hit_d = hit_q;
    if (val > on_th) begin
      hit_d = 1'b1;
    end else if (val < off_th) begin
      hit_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end
endmodule : wrp_hyst
`default_nettype wire

// ---- verilog/wrp_sticky.sv ----
`timescale 1ns/10ps
`default_nettype none
module wrp_sticky #(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output var  logic [W-1:0] flag_q
);
  logic [W-1:0] flag_d;

  // A set in the cycle of its clear wins.
  always_comb begin
    flag_d = (flag_q & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule : wrp_sticky
`default_nettype wire

// ---- verilog/wrp_supervisor.sv ----
`timescale 1ns/10ps
`default_nettype none
module wrp_supervisor
  import wrp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        shutdown_req_pin,
  input  wire logic        adc_valid,
  input  wire logic [15:0] rail_mv,
  input  wire logic [15:0] iout_ma,
  input  wire logic [7:0]  die_temp_c,
  input  wire logic [11:0] vsel_code,
  input  wire logic [11:0] current_limit_pin_code,
  input  wire logic [11:0] therm_code,
  input  wire logic        tx_5w_only,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  output var  logic        adc_start_q,
  output var  logic        sync_rect_q,
  output var  logic        reg_en_q,
  output var  logic        out_hiz_q,
  output var  logic [1:0]  vout_sel_q,
  output var  logic [6:0]  qfactor_q,
  output var  logic [15:0] current_limit_pin_ma_q,
  output var  logic        cur_limit_q,
  output var  logic        freq_up_q,
  output var  logic        freq_down_q,
  output var  logic        error_pkt_q,
  output var  logic        power_stop_q,
  output var  logic        clamp_drain_pin_o,
  output var  logic        clamp_drain_pin_oe,
  output var  logic        fault_alert_o,
  output var  logic        fault_alert_oe
);
  logic        shut_meta_q;
  logic        shut_sync_q;
  logic [7:0]  samp_cnt_q;
  logic [7:0]  samp_cnt_d;
  logic        adc_start_d;
  logic        samp_new_q;
  logic [15:0] rail_q;
  logic [15:0] iout_q;
  logic [7:0]  temp_q;
  logic [11:0] vsel_q;
  logic [11:0] current_limit_pin_q;
  logic [11:0] therm_q;
  logic        undervoltage_lockout_ok;
  logic        ov_q;
  logic        die_hot;
  logic        therm_fault_q;
  logic        eoc_q;
  logic        die_warn_q;
  logic        warn_prev_q;
  logic        eoc_prev_q;
  wrp_state_t  state_q;
  wrp_state_t  state_d;
  logic [15:0] target_q;
  logic [15:0] target_d;
  logic [15:0] base_mv;
  logic [15:0] drop_mv;
  logic [1:0]  pin_vout;
  logic [6:0]  pin_q;
  logic [15:0] current_limit_pin_d;
  logic        shut_cond;
  logic        reg_en_d;
  logic        sync_d;
  logic        hiz_d;
  logic [1:0]  vout_d;
  logic        cur_lim_d;
  logic        up_d;
  logic        down_d;
  logic        err_d;
  logic        stop_d;
  logic        alert_d;
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic [6:0]  mask_q;
  logic [6:0]  mask_d;
  logic [31:0] rdata_d;
  logic [6:0]  st_set;
  logic [6:0]  st_clr;
  logic [6:0]  status_q;

  // Band index within the select pin range picks the quality factor.
  function automatic logic [6:0] q_from_pin(input logic [11:0] code);
    logic [2:0]  idx;
    logic [11:0] th;
    idx = 3'h0;
    th  = 12'h000;
    for (int k = 1; k < 5; k++) begin
      if (code >= VSEL_12_CODE) begin
        th = VSEL_12_CODE + 12'(k) * VSEL_12_STEP;
        if (code >= th) idx = 3'(k);
      end else begin
        th = VSEL_9_HI_CODE - 12'(k) * VSEL_9_STEP;
        if (code < th) idx = 3'(k);
      end
    end
    case (idx)
      3'h0:    q_from_pin = 7'h67;
      3'h1:    q_from_pin = 7'h50;
      3'h2:    q_from_pin = 7'h3c;
      3'h3:    q_from_pin = 7'h28;
      default: q_from_pin = 7'h14;
    endcase
  endfunction : q_from_pin

  always_ff @(posedge clk) begin
    if (rst) begin
      shut_meta_q <= 1'b0;
      shut_sync_q <= 1'b0;
    end else begin
      shut_meta_q <= shutdown_req_pin;
      shut_sync_q <= shut_meta_q;
    end
  end

  always_comb begin
    samp_cnt_d  = samp_cnt_q + 8'h01;
    adc_start_d = 1'b0;
    if (samp_cnt_q == 8'(SAMPLE_CYC - 1)) begin
      samp_cnt_d  = 8'h00;
      adc_start_d = 1'b1;
    end
  end

  // Converter results are held in flops before any threshold looks at them.
  always_ff @(posedge clk) begin
    if (rst) begin
      samp_cnt_q  <= 8'h00;
      adc_start_q <= 1'b0;
      samp_new_q  <= 1'b0;
      rail_q      <= 16'h0000;
      iout_q      <= 16'h0000;
      temp_q      <= 8'h00;
      vsel_q      <= 12'hfff;
      current_limit_pin_q      <= 12'hfff;
      therm_q     <= 12'hfff;
    end else begin
      samp_cnt_q  <= samp_cnt_d;
      adc_start_q <= adc_start_d;
      samp_new_q  <= adc_valid;
      if (adc_valid) begin
        rail_q  <= rail_mv;
        iout_q  <= iout_ma;
        temp_q  <= die_temp_c;
        vsel_q  <= vsel_code;
        current_limit_pin_q  <= current_limit_pin_code;
        therm_q <= therm_code;
      end
    end
  end

  wrp_hyst #(.W(16)) u_undervoltage_lockout (
    .clk    (clk),
    .rst    (rst),
    .val    (rail_q),
    .on_th  (UNDERVOLTAGE_LOCKOUT_RISE_MV),
    .off_th (UNDERVOLTAGE_LOCKOUT_RISE_MV - UNDERVOLTAGE_LOCKOUT_HYS_MV),
    .hit_q  (undervoltage_lockout_ok)
  );

  wrp_hyst #(.W(16)) u_ov (
    .clk    (clk),
    .rst    (rst),
    .val    (rail_q),
    .on_th  (OV_RISE_MV),
    .off_th (OV_RISE_MV - OV_HYS_MV),
    .hit_q  (ov_q)
  );

  wrp_hyst #(.W(8)) u_die (
    .clk    (clk),
    .rst    (rst),
    .val    (temp_q),
    .on_th  (DIE_SHUT_C),
    .off_th (DIE_COOL_C),
    .hit_q  (die_hot)
  );

  always_comb begin
    base_mv  = RAIL_BASE_12_MV;
    pin_vout = WRP_OUT_12V;
    if (vsel_q >= VSEL_9_LO_CODE && vsel_q <= VSEL_9_HI_CODE) begin
      base_mv  = RAIL_BASE_9_MV;
      pin_vout = WRP_OUT_9V;
    end
    drop_mv = {2'b00, iout_q[15:2]};
    if (drop_mv > RAIL_DROOP_MAX) drop_mv = RAIL_DROOP_MAX;
    target_d = base_mv - drop_mv;
    if (current_limit_pin_q >= CURRENT_LIMIT_PIN_PULL_CODE) current_limit_pin_d = CURRENT_LIMIT_PIN_16_MA;
    else if (current_limit_pin_q >= CURRENT_LIMIT_PIN_1A_CODE) current_limit_pin_d = CURRENT_LIMIT_PIN_10_MA;
    else if (current_limit_pin_q >= CURRENT_LIMIT_PIN_08_CODE) current_limit_pin_d = CURRENT_LIMIT_PIN_08_MA;
    else current_limit_pin_d = CURRENT_LIMIT_PIN_05_MA;
  end

  assign shut_cond = shut_sync_q | die_hot | therm_fault_q | eoc_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      WRP_PASSIVE: begin
        if (shut_cond) state_d = WRP_SHUTDOWN;
        else if (undervoltage_lockout_ok) state_d = WRP_ACTIVE;
      end
      WRP_ACTIVE: begin
        if (shut_cond) state_d = WRP_SHUTDOWN;
        else if (!undervoltage_lockout_ok) state_d = WRP_PASSIVE;
      end
      WRP_SHUTDOWN: begin
        if (!shut_cond) state_d = WRP_PASSIVE;
      end
      default: state_d = WRP_PASSIVE;
    endcase
    sync_d    = (state_d == WRP_ACTIVE);
    reg_en_d  = sync_d && !ov_q;
    vout_d    = pin_vout;
    hiz_d     = !reg_en_d;
    if (tx_5w_only) begin
      if (ctrl_q[0]) vout_d = WRP_OUT_5V;
      else hiz_d = 1'b1;
    end
    cur_lim_d = reg_en_d && (iout_q > current_limit_pin_q_ma());
    up_d      = samp_new_q && state_q == WRP_ACTIVE && rail_q > target_q + RAIL_BAND_MV;
    down_d    = samp_new_q && state_q == WRP_ACTIVE && rail_q + RAIL_BAND_MV < target_q;
    err_d     = samp_new_q && ov_q;
    stop_d    = (die_warn_q && !warn_prev_q) || (eoc_q && !eoc_prev_q);
    alert_d   = shut_sync_q || ((status_q & mask_q) != 7'h00);
  end

  function automatic logic [15:0] current_limit_pin_q_ma();
    current_limit_pin_q_ma = current_limit_pin_ma_q;
  endfunction : current_limit_pin_q_ma

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q            <= WRP_PASSIVE;
      target_q           <= RAIL_BASE_12_MV;
      sync_rect_q        <= 1'b0;
      reg_en_q           <= 1'b0;
      out_hiz_q          <= 1'b1;
      vout_sel_q         <= WRP_OUT_12V;
      qfactor_q          <= 7'h67;
      pin_q              <= 7'h67;
      current_limit_pin_ma_q          <= CURRENT_LIMIT_PIN_16_MA;
      cur_limit_q        <= 1'b0;
      freq_up_q          <= 1'b0;
      freq_down_q        <= 1'b0;
      error_pkt_q        <= 1'b0;
      power_stop_q       <= 1'b0;
      therm_fault_q      <= 1'b0;
      eoc_q              <= 1'b0;
      die_warn_q         <= 1'b0;
      warn_prev_q        <= 1'b0;
      eoc_prev_q         <= 1'b0;
      clamp_drain_pin_oe <= 1'b0;
      fault_alert_oe     <= 1'b0;
    end else begin
      state_q            <= state_d;
      target_q           <= target_d;
      sync_rect_q        <= sync_d;
      reg_en_q           <= reg_en_d;
      out_hiz_q          <= hiz_d;
      vout_sel_q         <= vout_d;
      pin_q              <= q_from_pin(vsel_q);
      qfactor_q          <= pin_q;
      current_limit_pin_ma_q          <= current_limit_pin_d;
      cur_limit_q        <= cur_lim_d;
      freq_up_q          <= up_d;
      freq_down_q        <= down_d;
      error_pkt_q        <= err_d;
      power_stop_q       <= stop_d;
      therm_fault_q      <= therm_q >= THERM_LO_CODE && therm_q <= THERM_HI_CODE;
      eoc_q              <= therm_q < THERM_LO_CODE;
      die_warn_q         <= temp_q > DIE_WARN_C;
      warn_prev_q        <= die_warn_q;
      eoc_prev_q         <= eoc_q;
      clamp_drain_pin_oe <= ov_q;
      fault_alert_oe     <= alert_d;
    end
  end

  assign clamp_drain_pin_o = 1'b0;
  assign fault_alert_o     = 1'b0;

  always_comb begin
    st_set              = 7'h00;
    st_set[ST_SHUT_PIN] = shut_sync_q;
    st_set[ST_DIE_HOT]  = die_hot;
    st_set[ST_THERM]    = therm_fault_q;
    st_set[ST_OC]       = cur_limit_q;
    st_set[ST_OV]       = ov_q;
    st_set[ST_DIE_WARN] = die_warn_q;
    st_set[ST_EOC]      = eoc_q;
    st_clr              = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[6:0] : 7'h00;
  end

  wrp_sticky #(.W(7)) u_status (
    .clk    (clk),
    .rst    (rst),
    .set    (st_set),
    .clr    (st_clr),
    .flag_q (status_q)
  );

  always_comb begin
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr && reg_addr == REG_CTRL) ctrl_d = reg_wdata[1:0];
    if (reg_wr && reg_addr == REG_MASK) mask_d = reg_wdata[6:0];
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   rdata_d = {30'h0, ctrl_q};
        REG_MASK:   rdata_d = {25'h0, mask_q};
        REG_STATUS: rdata_d = {25'h0, status_q};
        REG_MEAS:   rdata_d = {iout_q, rail_q};
        REG_STATE:  rdata_d = {15'h0, cur_limit_q, clamp_drain_pin_oe, qfactor_q,
                               vout_sel_q, 4'h0, state_q};
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q    <= CTRL_RESET;
      mask_q    <= MASK_RESET;
      reg_rdata <= 32'h0000_0000;
    end else begin
      ctrl_q    <= ctrl_d;
      mask_q    <= mask_d;
      reg_rdata <= rdata_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  passive_start_a: assert property (!undervoltage_lockout_ok |=> !sync_rect_q)
    else $error("synchronous mode entered under lockout");
  undervoltage_lockout_release_a: assert property ($rose(undervoltage_lockout_ok) |-> $past(rail_q) > UNDERVOLTAGE_LOCKOUT_RISE_MV)
    else $error("lockout released below rising level");
  sample_period_a: assert property (adc_start_q |=> !adc_start_q [*8])
    else $error("sample requests too close");
  freq_dir_a: assert property (freq_down_q |-> !freq_up_q && $past(rail_q) < $past(target_q))
    else $error("frequency request points the wrong way");
  target_droop_a: assert property ($stable(vsel_q) && iout_q > $past(iout_q)
    |=> target_q <= $past(target_q))
    else $error("rail target rose with load");
  ov_clamp_a: assert property (ov_q |=> clamp_drain_pin_oe && !reg_en_q)
    else $error("excess voltage not clamped");
  clamp_release_a: assert property ($fell(ov_q) |-> $past(rail_q) < OV_RISE_MV - OV_HYS_MV)
    else $error("clamp released too early");
  alert_hold_a: assert property ((status_q & mask_q) != 7'h00 |=> fault_alert_oe)
    else $error("alert released with pending status");
  shutdown_pin_a: assert property (shut_sync_q |=> state_q == WRP_SHUTDOWN)
    else $error("shutdown request ignored");
endmodule : wrp_supervisor
`default_nettype wire

// ---- verif/wrp_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module wrp_far_model #(
  parameter int DLY = 3
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic adc_start_q,
  input  wire logic fault_alert_o,
  input  wire logic fault_alert_oe,
  output var  logic adc_valid,
  output wire logic alert_n
);
  logic [3:0] cnt_q;
  // The converter answers each start request after a fixed conversion time.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q     <= 4'h0;
      adc_valid <= 1'b0;
    end else begin
      adc_valid <= (cnt_q == 4'h1);
      if (adc_start_q) begin
        cnt_q <= DLY[3:0];
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  // The alert wire has a pull-up on the host side.
  assign alert_n = fault_alert_oe ? fault_alert_o : 1'b1;
endmodule : wrp_far_model
`default_nettype wire

// ---- verif/test_wrp_supervisor.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_wrp_supervisor;
  import wrp_pkg::*;
  logic        clk, rst, shutdown_req_pin, tx_5w_only, reg_wr, reg_rd;
  logic        adc_valid, alert_n;
  logic [15:0] rail_mv, iout_ma;
  logic [7:0]  die_temp_c, reg_addr;
  logic [11:0] vsel_code, current_limit_pin_code, therm_code;
  logic [31:0] reg_wdata, reg_rdata, s;
  logic        adc_start_q, sync_rect_q, reg_en_q, out_hiz_q, cur_limit_q;
  logic        freq_up_q, freq_down_q, error_pkt_q, power_stop_q;
  logic        clamp_o, clamp_oe, fault_alert_o, fault_alert_oe;
  logic [1:0]  vout_sel_q;
  logic [6:0]  qfactor_q;
  logic [15:0] current_limit_pin_ma_q;
  int          err_count, num_checks, nup, ndn, nerr, nstop, k;
  logic [11:0] codes[4] = '{12'h924, 12'h400, 12'h2aa, 12'h100};
  logic [15:0] lims[4]  = '{16'h0640, 16'h03e8, 16'h0320, 16'h01f4};

  wrp_supervisor u_dut (.clk(clk), .rst(rst), .shutdown_req_pin(shutdown_req_pin),
    .adc_valid(adc_valid), .rail_mv(rail_mv), .iout_ma(iout_ma), .die_temp_c(die_temp_c),
    .vsel_code(vsel_code), .current_limit_pin_code(current_limit_pin_code), .therm_code(therm_code),
    .tx_5w_only(tx_5w_only), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_start_q(adc_start_q),
    .sync_rect_q(sync_rect_q), .reg_en_q(reg_en_q), .out_hiz_q(out_hiz_q),
    .vout_sel_q(vout_sel_q), .qfactor_q(qfactor_q), .current_limit_pin_ma_q(current_limit_pin_ma_q),
    .cur_limit_q(cur_limit_q), .freq_up_q(freq_up_q), .freq_down_q(freq_down_q),
    .error_pkt_q(error_pkt_q), .power_stop_q(power_stop_q), .clamp_drain_pin_o(clamp_o),
    .clamp_drain_pin_oe(clamp_oe), .fault_alert_o(fault_alert_o),
    .fault_alert_oe(fault_alert_oe));
  wrp_far_model u_far (.clk(clk), .rst(rst), .adc_start_q(adc_start_q),
    .fault_alert_o(fault_alert_o), .fault_alert_oe(fault_alert_oe),
    .adc_valid(adc_valid), .alert_n(alert_n));

  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // Waits for n converter results and counts the pulses that follow each.
  task automatic sample(input int n);
    nup = 0;
    ndn = 0;
    nerr = 0;
    nstop = 0;
    repeat (n) begin
      @(posedge adc_valid);
      repeat (8) begin
        @(negedge clk);
        nup += int'(freq_up_q);
        ndn += int'(freq_down_q);
        nerr += int'(error_pkt_q);
        nstop += int'(power_stop_q);
      end
    end
  endtask : sample

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    print_verdict;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {shutdown_req_pin, tx_5w_only, reg_wr, reg_rd} = 4'h0;
    {rail_mv, iout_ma, reg_addr, reg_wdata} = '0;
    die_temp_c = 8'h19;
    {vsel_code, current_limit_pin_code, therm_code} = {3{12'hfff}};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("sync", 0, 32'(sync_rect_q));
    chk("hiz", 1, 32'(out_hiz_q));
    chk("q", 103, 32'(qfactor_q));
    chk("current_limit_pin", 1600, 32'(current_limit_pin_ma_q));
    chk("alert", 1, 32'(alert_n));
    rd(REG_CTRL, s);
    chk("ctrl", 32'(CTRL_RESET), s);
    rd(REG_MASK, s);
    chk("mask", 32'(MASK_RESET), s);
    rd(8'h40, s);
    chk("unmapped", 0, s);
    @(posedge adc_start_q);
    @(negedge clk);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (adc_start_q !== 1'b1 && k < 400);
    chk("period", SAMPLE_CYC, k);
    $display("test reset done");
    foreach (lims[i]) begin
      @(posedge clk) rail_mv <= lims[i] == 16'h0640 ? 16'h0bb8 : 16'h0af0;
      sample(1);
      chk("undervoltage_lockout", 1, 32'(sync_rect_q));
    end
    @(posedge clk) rail_mv <= 16'h0a28;
    sample(1);
    chk("undervoltage_lockout off", 0, 32'(sync_rect_q));
    @(posedge clk) rail_mv <= 16'h300c;
    sample(2);
    $display("test lockout done");
    @(posedge clk) rail_mv <= 16'h2af8;
    sample(2);
    chk("down", 1, 32'(ndn != 0 && nup == 0));
    @(posedge clk) rail_mv <= 16'h32c8;
    sample(2);
    chk("up", 1, 32'(nup != 0 && ndn == 0));
    @(posedge clk) rail_mv <= 16'h2f44;
    sample(2);
    chk("down 0ma", 1, 32'(ndn != 0 && nup == 0));
    @(posedge clk) iout_ma <= 16'h0578;
    sample(1);
    sample(2);
    chk("up 1400ma", 1, 32'(nup != 0 && ndn == 0));
    @(posedge clk) iout_ma <= 16'h0000;
    $display("test frequency done");
    @(posedge clk) rail_mv <= 16'h36b0;
    sample(2);
    chk("clamp", 1, 32'(clamp_oe));
    chk("clamp lvl", 0, 32'(clamp_o));
    chk("reg off", 0, 32'(reg_en_q));
    chk("err pkt", 1, 32'(nerr != 0));
    chk("ov alert", 0, 32'(alert_n));
    rd(REG_STATUS, s);
    chk("st ov", 1, 32'(s[ST_OV]));
    @(posedge clk) rail_mv <= 16'h32c8;
    sample(2);
    chk("clamp hold", 1, 32'(clamp_oe));
    @(posedge clk) rail_mv <= 16'h2ee0;
    sample(2);
    chk("clamp off", 0, 32'(clamp_oe));
    wr(REG_STATUS, 32'h7f);
    rd(REG_STATUS, s);
    chk("st clr", 0, s);
    chk("alert off", 1, 32'(alert_n));
    $display("test overvoltage done");
    @(posedge clk) rail_mv <= 16'h300c;
    foreach (codes[i]) begin
      @(posedge clk) current_limit_pin_code <= codes[i];
      sample(1);
      chk("current_limit_pin", 32'(lims[i]), 32'(current_limit_pin_ma_q));
    end
    @(posedge clk) current_limit_pin_code <= 12'hfff;
    @(posedge clk) iout_ma <= 16'h06a4;
    sample(2);
    chk("climit", 1, 32'(cur_limit_q));
    chk("reg kept", 1, 32'(reg_en_q));
    chk("oc alert", 0, 32'(alert_n));
    rd(REG_STATUS, s);
    chk("st oc", 1, 32'(s[ST_OC]));
    rd(REG_MEAS, s);
    chk("meas", 32'h06a4_300c, s);
    wr(REG_MASK, 32'h0);
    rd(REG_MASK, s);
    chk("mask wr", 0, s);
    chk("masked", 1, 32'(alert_n));
    wr(REG_MASK, 32'h7f);
    @(posedge clk) iout_ma <= 16'h0000;
    sample(1);
    wr(REG_STATUS, 32'h7f);
    $display("test current done");
    @(posedge clk) vsel_code <= 12'h700;
    sample(1);
    chk("vsel 9", 1, 32'(vout_sel_q));
    chk("q 9v", 60, 32'(qfactor_q));
    rd(REG_STATE, s);
    chk("st vout", 1, 32'(s[7:6]));
    @(posedge clk) vsel_code <= 12'hfff;
    sample(1);
    chk("vsel 12", 0, 32'(vout_sel_q));
    chk("q 12v", 20, 32'(qfactor_q));
    @(posedge clk) tx_5w_only <= 1'b1;
    sample(2);
    chk("vsel 5", 2, 32'(vout_sel_q));
    wr(REG_CTRL, 32'h0);
    sample(2);
    chk("hiz 5w", 1, 32'(out_hiz_q));
    @(posedge clk) tx_5w_only <= 1'b0;
    wr(REG_CTRL, 32'h1);
    $display("test output select done");
    @(posedge clk) die_temp_c <= 8'h87;
    sample(2);
    chk("stop pkt", 1, nstop);
    @(posedge clk) die_temp_c <= 8'h91;
    sample(2);
    chk("hot reg", 0, 32'(reg_en_q));
    chk("hot alert", 0, 32'(alert_n));
    rd(REG_STATUS, s);
    chk("st hot", 3, 32'({s[ST_DIE_WARN], s[ST_DIE_HOT]}));
    @(posedge clk) die_temp_c <= 8'h6e;
    sample(1);
    wr(REG_STATUS, 32'h7f);
    rd(REG_STATUS, s);
    chk("cool alert", 1, 32'(alert_n));
    @(posedge clk) therm_code <= 12'h200;
    sample(2);
    chk("ts alert", 0, 32'(alert_n));
    @(posedge clk) therm_code <= 12'h050;
    sample(2);
    chk("eoc stop", 1, 32'(nstop != 0));
    rd(REG_STATUS, s);
    chk("st ts", 3, 32'({s[ST_EOC], s[ST_THERM]}));
    @(posedge clk) therm_code <= 12'hfff;
    sample(2);
    wr(REG_STATUS, 32'h7f);
    $display("test thermal done");
    @(posedge clk) shutdown_req_pin <= 1'b1;
    repeat (6) @(negedge clk);
    chk("pin reg", 0, 32'(reg_en_q));
    chk("pin alert", 0, 32'(alert_n));
    rd(REG_STATUS, s);
    chk("st pin", 1, 32'(s[ST_SHUT_PIN]));
    @(posedge clk) shutdown_req_pin <= 1'b0;
    sample(2);
    wr(REG_STATUS, 32'h7f);
    rd(REG_STATUS, s);
    chk("st end", 0, s);
    chk("pin on", 1, 32'(reg_en_q));
    $display("test shutdown done");
    print_verdict;
  end
endmodule : test_wrp_supervisor
`default_nettype wire
